// File: src/cap_sense_accumulate_compare.sv
// Capacitive sense conversion control, accumulate, compare and auto-scan
//
// Behaviour
// - Consecutive conversions on one channel are summed, 1/4/8/16/32/64.
// - The 22-bit sum is divided by the count into the 16-bit result bytes.
// - When accumulating, the compare uses only the final divided value.
// - In auto-scan a greater-than result halts scanning, channel unchanged.
// - In auto-scan with no hit the channel steps up, wrapping end to start.
// - The done flag is set per finished result; only software or sync clear clears it.
// - The busy bit reads one exactly while a conversion is in progress.
// - Writing one to busy starts a conversion only in modes 000, 110, 111.
// - With enable low the converter is held off in a low-power state.
// - The comparator works only when its enable bit is one.
// - The exceeded flag shows a result above threshold; software can't write.
// - Accumulate codes 000..101 mean 1,4,8,16,32,64; 110 and 111 reserved.
// - Start modes: write, three timers, continuous, continuous auto-scan.
// - A scan halted on a hit restarts only on a software write of busy.
`timescale 1ns/10ps
`include "cap_sense_regs.svh"

module cap_sense_accumulate_compare
   import cap_sense_pkg::*;
#(
   parameter int SAMPLE_W = 16,
   parameter int SUM_W = 22,
   parameter int CHAN_W = 5
) (
   // Clock and resets
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic sync_clear_in,
   // Special function register access
   input wire logic [7:0] sfr_addr_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic sfr_write_in,
   input wire logic sfr_read_in,
   output logic [7:0] sfr_rdata_out,
   // Trigger sources
   input wire logic [2:0] timer_overflow_in,
   // Measurement front end
   input wire logic sample_valid_in,
   input wire logic [SAMPLE_W-1:0] sample_data_in,
   output logic sample_request_out,
   output logic [CHAN_W-1:0] channel_select_out,
   output logic sense_powered_out,
   // Status toward the system
   output logic conversion_done_out,
   output logic threshold_exceeded_out,
   output logic convert_busy_out
);

   generate
      if (SAMPLE_W != 16 || CHAN_W < 1 || CHAN_W > 8) begin : g_bad_param
         $error("unsupported sample or channel width");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Register state

   conv_state_t state_reg;
   logic sense_enable_bit;
   logic conversion_done_flag;
   logic threshold_compare_enable;
   logic threshold_exceeded_flag;
   logic [2:0] start_mode_field;
   logic [2:0] accumulate_count_field;
   logic [15:0] result_reg;
   logic [15:0] threshold_reg;
   logic [CHAN_W-1:0] scan_start_channel;
   logic [CHAN_W-1:0] scan_end_channel;
   logic [CHAN_W-1:0] channel_select;
   logic scan_halted_reg;

   logic ctl_write;
   logic cfg_write;
   logic busy_write_one;
   logic write_start;
   logic timer_start;
   logic start_fire;
   logic acc_valid;
   logic [SAMPLE_W-1:0] acc_result;
   logic finish;
   logic greater;
   logic scan_mode;
   logic hit_halt;
   logic run_on;
   logic acc_clear;

   assign ctl_write = sfr_write_in && sfr_addr_in == `SENSE_CONTROL_ADDR;
   assign cfg_write = sfr_write_in && sfr_addr_in == `SENSE_CONFIG_ADDR;
   assign busy_write_one = ctl_write && sfr_wdata_in[`BUSY_BIT_POS];
   assign scan_mode = start_mode_field == `MODE_AUTO_SCAN;

   ////////////////////////////////////////////////////////////////////////
   // Start sources

   // Enable and start may share one write; starts while running are dropped
   assign write_start = busy_write_one && sfr_wdata_in[`ENABLE_BIT_POS]
      && state_reg == ST_IDLE
      && (start_mode_field == `MODE_ON_WRITE
          || start_mode_field == `MODE_CONTINUOUS
          || scan_mode);

   always_comb begin
      case (start_mode_field)
         3'h1: timer_start = timer_overflow_in[0];
         3'h2: timer_start = timer_overflow_in[1];
         3'h3: timer_start = timer_overflow_in[2];
         default: timer_start = 1'b0;
      endcase
   end

   assign start_fire = write_start
      || (timer_start && sense_enable_bit && state_reg == ST_IDLE);

   ////////////////////////////////////////////////////////////////////////
   // Accumulator

   assign acc_clear = sync_clear_in || !sense_enable_bit || start_fire;

   sample_accumulator #(
      .SAMPLE_W(SAMPLE_W),
      .SUM_W(SUM_W)
   ) u_accumulator (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .clear_in(acc_clear),
      .sample_valid_in(sample_valid_in && state_reg == ST_WAIT),
      .sample_in(sample_data_in),
      .accumulate_code_in(accumulate_count_field),
      .result_valid_out(acc_valid),
      .result_out(acc_result)
   );

   // The accumulator answers one cycle after the last sample
   assign finish = state_reg == ST_SUM && acc_valid;
   assign greater = threshold_compare_enable
      && acc_result > threshold_reg;
   assign hit_halt = scan_mode && greater;
   assign run_on = start_mode_field == `MODE_CONTINUOUS
      || (scan_mode && !hit_halt && !scan_halted_reg);

   ////////////////////////////////////////////////////////////////////////
   // Conversion sequencer

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_reg <= ST_IDLE;
         sample_request_out <= 1'b0;
      end else if (sync_clear_in || (!sense_enable_bit && !write_start)) begin
         state_reg <= ST_IDLE;
         sample_request_out <= 1'b0;
      end else begin
         sample_request_out <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (start_fire) begin
                  state_reg <= ST_WAIT;
                  sample_request_out <= 1'b1;
               end
            end
            ST_WAIT: begin
               if (sample_valid_in) begin
                  state_reg <= ST_SUM;
               end
            end
            ST_SUM: begin
               if (finish && !run_on) begin
                  state_reg <= ST_IDLE;
               end else begin
                  state_reg <= ST_WAIT;
                  sample_request_out <= 1'b1;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         convert_busy_out <= 1'b0;
      end else begin
         convert_busy_out <= !sync_clear_in && (start_fire
            || (state_reg != ST_IDLE && sense_enable_bit
                && !(finish && !run_on)));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control and configuration registers

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sense_enable_bit <= 1'b0;
         threshold_compare_enable <= 1'b0;
      end else if (sync_clear_in) begin
         sense_enable_bit <= 1'b0;
         threshold_compare_enable <= 1'b0;
      end else if (ctl_write) begin
         sense_enable_bit <= sfr_wdata_in[`ENABLE_BIT_POS];
         threshold_compare_enable <= sfr_wdata_in[`COMPARE_EN_POS];
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         conversion_done_flag <= 1'b0;
      end else if (sync_clear_in) begin
         conversion_done_flag <= 1'b0;
      end else if (finish) begin
         conversion_done_flag <= 1'b1;
      end else if (ctl_write) begin
         conversion_done_flag <= sfr_wdata_in[`DONE_FLAG_POS];
      end
   end

   // Follows every compare; writes from software never reach it
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         threshold_exceeded_flag <= 1'b0;
      end else if (sync_clear_in) begin
         threshold_exceeded_flag <= 1'b0;
      end else if (finish && threshold_compare_enable) begin
         threshold_exceeded_flag <= greater;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         scan_halted_reg <= 1'b0;
      end else if (sync_clear_in || busy_write_one) begin
         scan_halted_reg <= 1'b0;
      end else if (finish && hit_halt) begin
         scan_halted_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         start_mode_field <= 3'h0;
         accumulate_count_field <= 3'h0;
      end else if (sync_clear_in) begin
         start_mode_field <= 3'h0;
         accumulate_count_field <= 3'h0;
      end else if (cfg_write) begin
         start_mode_field <= sfr_wdata_in[`START_MODE_LSB+:3];
         accumulate_count_field <= sfr_wdata_in[`ACC_COUNT_LSB+:3];
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         threshold_reg <= 16'h0000;
         scan_start_channel <= '0;
         scan_end_channel <= '0;
      end else if (sfr_write_in) begin
         case (sfr_addr_in)
            `THRESHOLD_HIGH_ADDR: threshold_reg[15:8] <= sfr_wdata_in;
            `THRESHOLD_LOW_ADDR: threshold_reg[7:0] <= sfr_wdata_in;
            `SCAN_START_ADDR: scan_start_channel <= sfr_wdata_in[CHAN_W-1:0];
            `SCAN_END_ADDR: scan_end_channel <= sfr_wdata_in[CHAN_W-1:0];
            default: threshold_reg <= threshold_reg;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         result_reg <= 16'h0000;
      end else if (finish) begin
         result_reg <= acc_result;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Channel selection

   // Hardware stepping wins over a software write in the same cycle
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         channel_select <= '0;
      end else if (finish && scan_mode && !hit_halt) begin
         if (channel_select == scan_end_channel) begin
            channel_select <= scan_start_channel;
         end else begin
            channel_select <= channel_select + CHAN_W'(1);
         end
      end else if (sfr_write_in && sfr_addr_in == `CHANNEL_SELECT_ADDR) begin
         channel_select <= sfr_wdata_in[CHAN_W-1:0];
      end else if (sfr_write_in && sfr_addr_in == `SCAN_START_ADDR
                   && scan_mode) begin
         channel_select <= sfr_wdata_in[CHAN_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path and status outputs

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sfr_rdata_out <= `BYTE_RESET;
      end else if (sfr_read_in) begin
         case (sfr_addr_in)
            `SENSE_CONTROL_ADDR: sfr_rdata_out <= {sense_enable_bit, 1'b0,
               conversion_done_flag, convert_busy_out,
               threshold_compare_enable, 2'b00, threshold_exceeded_flag};
            `SENSE_CONFIG_ADDR: sfr_rdata_out <= {1'b0, start_mode_field,
               1'b0, accumulate_count_field};
            `RESULT_HIGH_ADDR: sfr_rdata_out <= result_reg[15:8];
            `RESULT_LOW_ADDR: sfr_rdata_out <= result_reg[7:0];
            `THRESHOLD_HIGH_ADDR: sfr_rdata_out <= threshold_reg[15:8];
            `THRESHOLD_LOW_ADDR: sfr_rdata_out <= threshold_reg[7:0];
            `SCAN_START_ADDR: sfr_rdata_out <= 8'(scan_start_channel);
            `SCAN_END_ADDR: sfr_rdata_out <= 8'(scan_end_channel);
            `CHANNEL_SELECT_ADDR: sfr_rdata_out <= 8'(channel_select);
            default: sfr_rdata_out <= `BYTE_RESET;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         channel_select_out <= '0;
         sense_powered_out <= 1'b0;
         conversion_done_out <= 1'b0;
         threshold_exceeded_out <= 1'b0;
      end else begin
         channel_select_out <= channel_select;
         sense_powered_out <= sense_enable_bit && !sync_clear_in;
         conversion_done_out <= conversion_done_flag;
         threshold_exceeded_out <= threshold_exceeded_flag;
      end
   end

endmodule

// File: src/cap_sense_regs.svh
// Register addresses, field positions and reset values of the sense block
`ifndef CAP_SENSE_REGS_SVH
`define CAP_SENSE_REGS_SVH

`define SENSE_CONTROL_ADDR 8'hb0
`define SENSE_CONFIG_ADDR 8'h9e
`define RESULT_HIGH_ADDR 8'hac
`define RESULT_LOW_ADDR 8'hab
`define SCAN_START_ADDR 8'hb9
`define SCAN_END_ADDR 8'hba
`define THRESHOLD_HIGH_ADDR 8'h97
`define THRESHOLD_LOW_ADDR 8'h96
`define CHANNEL_SELECT_ADDR 8'h9c

`define ENABLE_BIT_POS 7
`define DONE_FLAG_POS 5
`define BUSY_BIT_POS 4
`define COMPARE_EN_POS 3
`define EXCEEDED_FLAG_POS 0
`define START_MODE_LSB 4
`define ACC_COUNT_LSB 0

`define MODE_ON_WRITE 3'h0
`define MODE_CONTINUOUS 3'h6
`define MODE_AUTO_SCAN 3'h7

`define ACC_X1 3'h0
`define ACC_X4 3'h1
`define ACC_X8 3'h2
`define ACC_X16 3'h3
`define ACC_X32 3'h4
`define ACC_X64 3'h5

`define BYTE_RESET 8'h00

`endif

// File: src/cap_sense_pkg.sv
// Types shared by the capacitive sense control logic
package cap_sense_pkg;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT,
      ST_SUM
   } conv_state_t;

endpackage

// File: src/sample_accumulator.sv
// Sums a configured number of samples and divides the sum down
`timescale 1ns/10ps
`include "cap_sense_regs.svh"

module sample_accumulator
   import cap_sense_pkg::*;
#(
   parameter int SAMPLE_W = 16,
   parameter int SUM_W = 22
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic clear_in,
   // Samples
   input wire logic sample_valid_in,
   input wire logic [SAMPLE_W-1:0] sample_in,
   input wire logic [2:0] accumulate_code_in,
   // Result
   output logic result_valid_out,
   output logic [SAMPLE_W-1:0] result_out
);

   generate
      if (SUM_W < SAMPLE_W + 6) begin : g_bad_width
         $error("sum too narrow for 64 samples");
      end
   endgenerate

   logic [SUM_W-1:0] sum_reg;
   logic [SUM_W-1:0] sum_next;
   logic [SUM_W-1:0] quotient;
   logic [6:0] count_reg;
   logic [6:0] count_next;
   logic [6:0] target;
   logic [2:0] shift;

   // Reserved codes fall back to a single sample
   always_comb begin
      case (accumulate_code_in)
         `ACC_X4: shift = 3'h2;
         `ACC_X8: shift = 3'h3;
         `ACC_X16: shift = 3'h4;
         `ACC_X32: shift = 3'h5;
         `ACC_X64: shift = 3'h6;
         default: shift = 3'h0;
      endcase
   end

   assign target = 7'h01 << shift;
   assign sum_next = sum_reg + SUM_W'(sample_in);
   assign quotient = sum_next >> shift;
   assign count_next = count_reg + 7'h01;

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sum_reg <= '0;
         count_reg <= 7'h00;
         result_valid_out <= 1'b0;
         result_out <= '0;
      end else if (clear_in) begin
         sum_reg <= '0;
         count_reg <= 7'h00;
         result_valid_out <= 1'b0;
      end else if (sample_valid_in && count_next >= target) begin
         sum_reg <= '0;
         count_reg <= 7'h00;
         result_valid_out <= 1'b1;
         result_out <= quotient[SAMPLE_W-1:0];
      end else if (sample_valid_in) begin
         sum_reg <= sum_next;
         count_reg <= count_next;
         result_valid_out <= 1'b0;
      end else begin
         result_valid_out <= 1'b0;
      end
   end

endmodule

// File: verification/cap_sense_checker.sv
// Assertion checker for the capacitive sense control block
`timescale 1ns/10ps
`include "cap_sense_regs.svh"

module cap_sense_checker
   import cap_sense_pkg::*;
#(
   parameter int CHAN_W = 5
) (
   // Clock and resets
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic sync_clear_in,
   // Register access and triggers
   input wire logic [7:0] sfr_addr_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic sfr_write_in,
   input wire logic [2:0] timer_overflow_in,
   // Observed outputs
   input wire logic sample_request_out,
   input wire logic [CHAN_W-1:0] channel_select_out,
   input wire logic sense_powered_out,
   input wire logic conversion_done_out,
   input wire logic threshold_exceeded_out,
   input wire logic convert_busy_out
);
   logic [2:0] mode_reg;
   logic halted_reg;
   logic ctrl_wr, cfg_wr, busy_wr, chan_wr, auto_mode;

   assign ctrl_wr = sfr_write_in && sfr_addr_in == `SENSE_CONTROL_ADDR;
   assign cfg_wr = sfr_write_in && sfr_addr_in == `SENSE_CONFIG_ADDR;
   assign busy_wr = ctrl_wr && sfr_wdata_in[`BUSY_BIT_POS];
   assign chan_wr = sfr_write_in && (sfr_addr_in == `CHANNEL_SELECT_ADDR ||
      sfr_addr_in == `SCAN_START_ADDR);
   assign auto_mode = mode_reg == `MODE_AUTO_SCAN;

   ////////////////////////////////////////////////////////////////////////
   // Shadow of the start mode, kept in step with the design's own copy
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) mode_reg <= 3'h0;
      else if (sync_clear_in) mode_reg <= 3'h0;
      else if (cfg_wr) mode_reg <= sfr_wdata_in[6:4];
   end

   // Scan halted by a hit; only a busy write, reconfiguration or sync clear frees it
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) halted_reg <= 1'b0;
      else if (sync_clear_in || busy_wr || cfg_wr) halted_reg <= 1'b0;
      else if ($rose(threshold_exceeded_out) && auto_mode) halted_reg <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);

   sequence s_start_ok;
      busy_wr && sfr_wdata_in[`ENABLE_BIT_POS] && !convert_busy_out &&
         !sync_clear_in && (mode_reg == `MODE_ON_WRITE ||
         mode_reg == `MODE_CONTINUOUS || auto_mode);
   endsequence
   sequence s_req_soon;
      ##[1:2] sample_request_out;
   endsequence
   sequence s_start_refused;
      busy_wr && mode_reg inside {[3'h1:3'h5]} && !convert_busy_out &&
         timer_overflow_in == 3'h0 && $past(timer_overflow_in) == 3'h0;
   endsequence
   sequence s_clear_quiet;
      sync_clear_in ##1 !sfr_write_in;
   endsequence

   a_start_gives_req:
   assert property (s_start_ok |-> s_req_soon)
      else $error("busy write did not start a conversion");
   a_refused_start:
   assert property (s_start_refused |=> !sample_request_out)
      else $error("busy write started a conversion in a timer mode");
   a_req_one_pulse:
   assert property (sample_request_out |=> !sample_request_out)
      else $error("sample request longer than one cycle");
   a_done_stays_set:
   assert property (conversion_done_out && !ctrl_wr && !$past(ctrl_wr) &&
      !sync_clear_in && !$past(sync_clear_in) |=> conversion_done_out)
      else $error("done flag dropped without software");
   a_power_off:
   assert property (ctrl_wr && !sfr_wdata_in[`ENABLE_BIT_POS] |->
      ##2 !sense_powered_out)
      else $error("block still powered after enable cleared");
   a_clear_quiets:
   assert property (s_clear_quiet |-> ##1 (!conversion_done_out &&
      !threshold_exceeded_out && !sense_powered_out))
      else $error("sync clear left flags or power set");
   a_exceed_with_done:
   assert property ($rose(threshold_exceeded_out) |-> conversion_done_out)
      else $error("exceeded flag rose without a finished result");
   a_chan_manual_hold:
   assert property (!auto_mode && !chan_wr && !sync_clear_in |->
      ##2 $stable(channel_select_out))
      else $error("channel moved outside auto-scan");
   a_halt_no_request:
   assert property (halted_reg |-> !sample_request_out)
      else $error("conversion requested while scan halted");
endmodule

bind cap_sense_accumulate_compare cap_sense_checker #(.CHAN_W(CHAN_W)) chk (
   .clk_in(clk_in), .reset_n_in(reset_n_in), .sync_clear_in(sync_clear_in),
   .sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in),
   .sfr_write_in(sfr_write_in), .timer_overflow_in(timer_overflow_in),
   .sample_request_out(sample_request_out),
   .channel_select_out(channel_select_out),
   .sense_powered_out(sense_powered_out),
   .conversion_done_out(conversion_done_out),
   .threshold_exceeded_out(threshold_exceeded_out),
   .convert_busy_out(convert_busy_out)
);

// File: verification/testbench.sv
// Self-checking bench for the capacitive sense control block
`timescale 1ns/10ps
`include "cap_sense_regs.svh"
`define CHECK(a, e) check_val(32'(a), 32'(e))

module testbench;
   import cap_sense_pkg::*;
   logic clk_in = 1'b0, reset_n_in = 1'b0, sync_clear_in = 1'b0;
   logic [7:0] sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, sfr_rdata_out;
   logic sfr_write_in = 1'b0, sfr_read_in = 1'b0, sample_valid_in = 1'b0;
   logic [2:0] timer_overflow_in = 3'h0;
   logic [15:0] sample_data_in = 16'h0000;
   logic [4:0] channel_select_out;
   logic sample_request_out, sense_powered_out, conversion_done_out;
   logic threshold_exceeded_out, convert_busy_out;
   int n_tests = 0, bad_count = 0, n_req = 0, n_served = 0, cycles = 0;

   cap_sense_accumulate_compare dut (.clk_in(clk_in),
      .reset_n_in(reset_n_in), .sync_clear_in(sync_clear_in),
      .sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in),
      .sfr_write_in(sfr_write_in), .sfr_read_in(sfr_read_in),
      .sfr_rdata_out(sfr_rdata_out), .timer_overflow_in(timer_overflow_in),
      .sample_valid_in(sample_valid_in), .sample_data_in(sample_data_in),
      .sample_request_out(sample_request_out),
      .channel_select_out(channel_select_out),
      .sense_powered_out(sense_powered_out),
      .conversion_done_out(conversion_done_out),
      .threshold_exceeded_out(threshold_exceeded_out),
      .convert_busy_out(convert_busy_out));

   always #2.5 clk_in = ~clk_in;

   // Requests are counted here so a late answer never misses a pulse
   always @(posedge clk_in) begin
      n_req <= n_req + int'(sample_request_out === 1'b1);
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         conclude();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("counts: %0d compared, %0d mismatched", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   // Strobe lowered, then an edge passes before the next access
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr_in = a;
      sfr_wdata_in = d;
      sfr_write_in = 1'b1;
      tick(1);
      sfr_write_in = 1'b0;
      tick(1);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      sfr_addr_in = a;
      sfr_read_in = 1'b1;
      tick(1);
      sfr_read_in = 1'b0;
      tick(1);
      `CHECK(sfr_rdata_out, e);
   endtask
   task automatic serve(input logic [15:0] s);
      int k;
      k = 0;
      while (n_req <= n_served && k < 200) begin
         tick(1);
         k++;
      end
      `CHECK(n_req > n_served, 1'b1);
      sample_data_in = s;
      sample_valid_in = 1'b1;
      tick(1);
      sample_valid_in = 1'b0;
      n_served++;
      tick(1);
   endtask
   task automatic wait_idle();
      int k;
      k = 0;
      while (convert_busy_out !== 1'b0 && k < 300) begin
         tick(1);
         k++;
      end
      tick(2);
   endtask
   task automatic pulse(input logic [2:0] b);
      timer_overflow_in = b;
      tick(1);
      timer_overflow_in = 3'h0;
      tick(3);
   endtask
   task automatic clear_all();
      sync_clear_in = 1'b1;
      tick(1);
      sync_clear_in = 1'b0;
      tick(3);
      n_served = n_req;
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_single();
      wr(`SENSE_CONFIG_ADDR, 8'h00);
      wr(`SENSE_CONTROL_ADDR, 8'h90);
      `CHECK(sense_powered_out, 1'b1);
      serve(16'h1234);
      wait_idle();
      rd_chk(`RESULT_HIGH_ADDR, 8'h12);
      rd_chk(`RESULT_LOW_ADDR, 8'h34);
      rd_chk(`SENSE_CONTROL_ADDR, 8'ha0);
      tick(5);
      `CHECK(conversion_done_out, 1'b1);
      wr(`SENSE_CONTROL_ADDR, 8'h80);
      rd_chk(`SENSE_CONTROL_ADDR, 8'h80);
      rd_chk(8'h00, 8'h00);
      $display("test single done");
   endtask
   task automatic t_accum();
      logic [21:0] sum;
      logic [15:0] s;
      int cnt;
      for (int c = 1; c <= 6; c++) begin
         cnt = (c == 6) ? 1 : (c == 1) ? 4 : 1 << (c + 1);
         sum = 22'h0;
         wr(`SENSE_CONFIG_ADDR, 8'(c));
         wr(`SENSE_CONTROL_ADDR, 8'h90);
         for (int i = 0; i < cnt; i++) begin
            s = 16'(16'hfff0 - i * 37);
            sum = sum + 22'(s);
            serve(s);
         end
         wait_idle();
         rd_chk(`RESULT_HIGH_ADDR, 8'(sum / cnt >> 8));
         rd_chk(`RESULT_LOW_ADDR, 8'(sum / cnt));
         wr(`SENSE_CONTROL_ADDR, 8'h80);
      end
      $display("test accumulate done");
   endtask
   task automatic t_compare();
      logic [15:0] smp [3] = '{16'h1001, 16'h1000, 16'hffff};
      logic exp [3] = '{1'b1, 1'b0, 1'b1};
      wr(`THRESHOLD_HIGH_ADDR, 8'h10);
      wr(`THRESHOLD_LOW_ADDR, 8'h00);
      wr(`SENSE_CONFIG_ADDR, 8'h00);
      for (int i = 0; i < 3; i++) begin
         wr(`SENSE_CONTROL_ADDR, 8'h98);
         serve(smp[i]);
         wait_idle();
         `CHECK(threshold_exceeded_out, exp[i]);
      end
      wr(`SENSE_CONTROL_ADDR, 8'h90);
      serve(16'h0000);
      wait_idle();
      `CHECK(threshold_exceeded_out, 1'b1);
      wr(`SENSE_CONTROL_ADDR, 8'h80);
      rd_chk(`SENSE_CONTROL_ADDR, 8'h81);
      clear_all();
      $display("test compare done");
   endtask
   task automatic t_modes();
      logic [2:0] b;
      wr(`SENSE_CONTROL_ADDR, 8'h80);
      tick(3);
      `CHECK(n_req - n_served, 0);
      for (int m = 1; m <= 5; m++) begin
         b = (m <= 3) ? 3'(1 << (m - 1)) : 3'h0;
         wr(`SENSE_CONFIG_ADDR, 8'(m << 4));
         wr(`SENSE_CONTROL_ADDR, 8'h90);
         pulse(~b);
         `CHECK(n_req - n_served, 0);
         if (m <= 3) begin
            pulse(b);
            serve(16'h0001);
            wait_idle();
         end
      end
      wr(`SENSE_CONFIG_ADDR, 8'h60);
      wr(`SENSE_CONTROL_ADDR, 8'h90);
      serve(16'h0001);
      serve(16'h0002);
      `CHECK(convert_busy_out, 1'b1);
      clear_all();
      $display("test modes done");
   endtask
   task automatic t_scan();
      logic [4:0] ch [4] = '{5'h3, 5'h4, 5'h2, 5'h3};
      wr(`SENSE_CONFIG_ADDR, 8'h70);
      wr(`SENSE_CONTROL_ADDR, 8'h88);
      wr(`THRESHOLD_HIGH_ADDR, 8'h80);
      wr(`THRESHOLD_LOW_ADDR, 8'h00);
      wr(`SCAN_END_ADDR, 8'h04);
      wr(`SCAN_START_ADDR, 8'h02);
      `CHECK(channel_select_out, 5'h2);
      wr(`SENSE_CONTROL_ADDR, 8'h98);
      for (int i = 0; i < 4; i++) begin
         serve(16'h0100);
         tick(4);
         `CHECK(channel_select_out, ch[i]);
      end
      serve(16'h9000);
      tick(15);
      `CHECK(channel_select_out, 5'h3);
      `CHECK(threshold_exceeded_out, 1'b1);
      `CHECK(n_req - n_served, 0);
      wr(`SENSE_CONTROL_ADDR, 8'h98);
      serve(16'h0100);
      tick(4);
      `CHECK(channel_select_out, 5'h4);
      clear_all();
      rd_chk(`SENSE_CONTROL_ADDR, 8'h00);
      rd_chk(`SENSE_CONFIG_ADDR, 8'h00);
      `CHECK(sense_powered_out, 1'b0);
      wr(`SENSE_CONTROL_ADDR, 8'h10);
      tick(3);
      `CHECK(n_req - n_served, 0);
      rd_chk(`SENSE_CONTROL_ADDR, 8'h00);
      wr(`CHANNEL_SELECT_ADDR, 8'h07);
      rd_chk(`CHANNEL_SELECT_ADDR, 8'h07);
      rd_chk(`SCAN_END_ADDR, 8'h04);
      rd_chk(`THRESHOLD_HIGH_ADDR, 8'h80);
      $display("test scan done");
   endtask

   initial begin
      tick(6);
      reset_n_in = 1'b1;
      rd_chk(`SENSE_CONTROL_ADDR, 8'h00);
      rd_chk(`RESULT_HIGH_ADDR, 8'h00);
      t_single();
      t_accum();
      t_compare();
      t_modes();
      t_scan();
      conclude();
   end
endmodule
